// >>> core/fsb_bank.sv
// fieldbus select and status register bank with an ahb-lite slave port
`timescale 1ns/100ps
module fsb_bank
   import fsb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [31:0] deactivatable_pin,
   input wire logic [31:0] iface_active_pin,
   input wire logic [3:0] slave_bus_state_pin,
   input wire logic slave_err_pin,
   input wire logic slave_sync_pin,
   output logic [31:0] iface_enable,
   output logic drive_command_interface_en,
   output logic cmd_start,
   output logic [7:0] cmd_code,
   output logic irq
);
   // ---------------------------------------------------------------
   // pin synchronisers: first stage feeds only the second stage
   // ---------------------------------------------------------------
   localparam int SYNC_W = 70;
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   wire [SYNC_W-1:0] pins_raw = {deactivatable_pin, iface_active_pin,
      slave_bus_state_pin, slave_err_pin, slave_sync_pin};

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (clk_en) begin
         sync_a <= pins_raw;
         sync_b <= sync_a;
      end
   end

   wire [31:0] deact_s = sync_b[69:38];
   wire [31:0] active_s = sync_b[37:6];
   wire [3:0] state_s = sync_b[5:2];
   wire err_s = sync_b[1];
   wire sync_s = sync_b[0];

   // ---------------------------------------------------------------
   // bus front end: every transfer takes two wait states so that
   // record reads out of the registered memory line up with the rest
   // ---------------------------------------------------------------
   fsb_bus_phase_t phase;
   fsb_bus_phase_t next_phase;
   logic [19:0] addr_q;
   logic write_q;
   logic addr_ok_q;

   wire take = hsel && htrans[1] && hready && phase == FSB_ST_IDLE;
   wire in_range = haddr[31:20] == 12'h000 && haddr[1:0] == 2'b00;
   wire wr_now = phase == FSB_ST_WAIT && write_q && addr_ok_q;

   always_comb begin
      next_phase = phase;
      unique case (phase)
         FSB_ST_IDLE: begin
            if (take) begin
               next_phase = FSB_ST_WAIT;
            end
         end
         FSB_ST_WAIT: begin
            next_phase = FSB_ST_LOAD;
         end
         FSB_ST_LOAD: begin
            next_phase = FSB_ST_IDLE;
         end
         default: begin
            next_phase = FSB_ST_IDLE;
         end
      endcase
   end

   // address phase capture
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         phase <= FSB_ST_IDLE;
         addr_q <= 20'h00000;
         write_q <= 1'b0;
         addr_ok_q <= 1'b0;
      end else if (clk_en) begin
         phase <= next_phase;
         if (take) begin
            addr_q <= haddr[19:0];
            write_q <= hwrite;
            addr_ok_q <= in_range;
         end
      end
   end

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   wire sel_ctrl = addr_q == FSB_ADDR_CTRL;
   wire sel_count = addr_q == FSB_ADDR_COUNT;
   wire sel_dis = addr_q == FSB_ADDR_DIS_MASK;
   wire sel_enabled = addr_q == FSB_ADDR_ENABLED;
   wire sel_slave = addr_q == FSB_ADDR_SLAVE;
   wire sel_cmd_ctrl = addr_q == FSB_ADDR_CMD_CTRL;
   wire sel_rec_cnt = addr_q == FSB_ADDR_REC_COUNT;
   wire sel_irq_stat = addr_q == FSB_ADDR_IRQ_STAT;
   wire sel_irq_mask = addr_q == FSB_ADDR_IRQ_MASK;
   wire sel_rec = addr_q[19:4] == FSB_ADDR_REC_BASE[19:4];
   wire [1:0] rec_entry = addr_q[3:2];

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [31:0] ctrl;
   logic [31:0] dis_mask;
   logic [31:0] enabled_set;
   logic [15:0] slave_status;
   logic [7:0] cmd_ctrl;
   logic [FSB_IRQ_W-1:0] irq_stat;
   logic [FSB_IRQ_W-1:0] irq_mask;

   // only switchable and existing bits take the written value
   wire [31:0] wr_keep = dis_mask & FSB_USED_BITS;
   wire [31:0] next_ctrl = (hwdata & wr_keep) | (ctrl & ~wr_keep);

   // control word: interfaces in bits 0..6, protocols in 16..18
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         ctrl <= FSB_CTRL_RST;
      end else if (clk_en && wr_now && sel_ctrl) begin
         ctrl <= next_ctrl;
      end
   end

   // read-only status words track the synchronised pins, same layout
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         dis_mask <= FSB_DIS_MASK_RST;
         enabled_set <= FSB_ENABLED_RST;
      end else if (clk_en) begin
         dis_mask <= deact_s & FSB_USED_BITS;
         enabled_set <= active_s & FSB_USED_BITS;
      end
   end

   // unknown bus-state codes are dropped; the field keeps the last legal one
   logic state_legal;
   always_comb begin
      unique case (state_s)
         FSB_BUS_INIT, FSB_BUS_PREOP, FSB_BUS_BOOT,
         FSB_BUS_SAFEOP, FSB_BUS_OP: state_legal = 1'b1;
         default: state_legal = 1'b0;
      endcase
   end

   wire [3:0] next_state_field = state_legal ? state_s :
      slave_status[FSB_SLV_STATE_LSB +: 4];
   wire [15:0] next_slave = {10'h000, sync_s, err_s, next_state_field};

   // slave status word, read only from the bus side
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         slave_status <= FSB_SLAVE_RST;
      end else if (clk_en) begin
         slave_status <= next_slave;
      end
   end

   // command interface control byte, bit 0 enables the interface
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cmd_ctrl <= FSB_CMD_CTRL_RST;
      end else if (clk_en && wr_now && sel_cmd_ctrl) begin
         cmd_ctrl <= hwdata[7:0];
      end
   end

   // ---------------------------------------------------------------
   // input record memory
   // ---------------------------------------------------------------
   fsb_rec_if rec ();

   // record writes are only taken while the command interface is on
   wire rec_we = wr_now && sel_rec && cmd_ctrl[FSB_CMD_EN_BIT];
   assign rec.we = rec_we;
   assign rec.waddr = rec_entry;
   assign rec.wdata = hwdata;
   assign rec.raddr = rec_entry;

   fsb_rec_mem u_rec (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .rec(rec.mem)
   );

   wire cmd_write = rec_we && rec_entry == FSB_REC_CMD_ENTRY;

   // command strobe and code handed to the drive logic
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cmd_start <= 1'b0;
         cmd_code <= 8'h00;
      end else if (clk_en) begin
         cmd_start <= cmd_write;
         if (cmd_write) begin
            cmd_code <= hwdata[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // events and interrupt
   // ---------------------------------------------------------------
   wire [3:0] state_field = slave_status[FSB_SLV_STATE_LSB +: 4];
   wire ev_state = next_state_field != state_field;
   wire ev_err = err_s && !slave_status[FSB_SLV_ERR_BIT];
   wire ev_sync = sync_s != slave_status[FSB_SLV_SYNC_BIT];
   wire ev_active = (active_s & FSB_USED_BITS) != enabled_set;
   wire [FSB_IRQ_W-1:0] events = {cmd_write, ev_active, ev_sync, ev_err,
      ev_state};
   wire [FSB_IRQ_W-1:0] w1c = (wr_now && sel_irq_stat) ?
      hwdata[FSB_IRQ_W-1:0] : '0;
   // a new event beats a clear in the same cycle
   wire [FSB_IRQ_W-1:0] next_irq_stat = (irq_stat & ~w1c) | events;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         irq_stat <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else if (clk_en) begin
         irq_stat <= next_irq_stat;
         if (wr_now && sel_irq_mask) begin
            irq_mask <= hwdata[FSB_IRQ_W-1:0];
         end
         irq <= |(next_irq_stat & irq_mask);
      end
   end

   // ---------------------------------------------------------------
   // read mux; unmapped words read zero with an okay answer
   // ---------------------------------------------------------------
   wire [31:0] rd_ctrl = sel_ctrl ? ctrl : 32'h00000000;
   wire [31:0] rd_count = sel_count ? {24'h000000, FSB_STATUS_COUNT} :
      32'h00000000;
   wire [31:0] rd_dis = sel_dis ? dis_mask : 32'h00000000;
   wire [31:0] rd_en = sel_enabled ? enabled_set : 32'h00000000;
   wire [31:0] rd_slave = sel_slave ? {16'h0000, slave_status} :
      32'h00000000;
   wire [31:0] rd_cmd = sel_cmd_ctrl ? {24'h000000, cmd_ctrl} :
      32'h00000000;
   wire [31:0] rd_rcnt = sel_rec_cnt ? {24'h000000, FSB_REC_COUNT} :
      32'h00000000;
   wire [31:0] rd_ist = sel_irq_stat ? {27'h0000000, irq_stat} :
      32'h00000000;
   wire [31:0] rd_imk = sel_irq_mask ? {27'h0000000, irq_mask} :
      32'h00000000;
   wire [31:0] rd_rec = sel_rec ? rec.rdata : 32'h00000000;
   wire [31:0] rd_any = rd_ctrl | rd_count | rd_dis | rd_en | rd_slave |
      rd_cmd | rd_rcnt | rd_ist | rd_imk | rd_rec;
   wire [31:0] rd_word = (addr_ok_q && !write_q) ? rd_any : 32'h00000000;

   // response flops; hrdata loads as the final wait state ends
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else if (clk_en) begin
         hresp <= 1'b0;
         if (take) begin
            hreadyout <= 1'b0;
         end else if (phase == FSB_ST_LOAD) begin
            hreadyout <= 1'b1;
            hrdata <= rd_word;
         end
      end
   end

   // enables driven to the interface blocks
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         iface_enable <= FSB_CTRL_RST;
         drive_command_interface_en <= FSB_CMD_CTRL_RST[FSB_CMD_EN_BIT];
      end else if (clk_en) begin
         iface_enable <= ctrl & FSB_USED_BITS;
         drive_command_interface_en <= cmd_ctrl[FSB_CMD_EN_BIT];
      end
   end

   // hsize is accepted for word transfers only; narrower ones act as words
   wire unused_size = ^hsize;
endmodule // fsb_bank

// >>> core/fsb_rec_mem.sv
// input record store of the drive command interface
`timescale 1ns/100ps
module fsb_rec_mem
   import fsb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   fsb_rec_if.mem rec
);
   logic [31:0] store [FSB_REC_DEPTH];
   logic [31:0] rdata_q;

   // entries clear on reset so a fresh record never carries old targets
   genvar g;
   for (g = 0; g < FSB_REC_DEPTH; g++) begin : g_ent
      always_ff @(posedge sys_clk) begin
         if (!rst_n) begin
            store[g] <= 32'h00000000;
         end else if (clk_en && rec.we && rec.waddr == 2'(g)) begin
            store[g] <= rec.wdata;
         end
      end
   end

   // registered read port, one cycle behind the address
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h00000000;
      end else if (clk_en) begin
         rdata_q <= store[rec.raddr];
      end
   end

   assign rec.rdata = rdata_q;
endmodule // fsb_rec_mem

// >>> inc/fsb_pkg.sv
// constants and types of the fieldbus select and status register bank
package fsb_pkg;
   // object indices; byte address is four times the index
   localparam logic [15:0] FSB_IDX_CTRL = 16'h2102;
   localparam logic [15:0] FSB_IDX_STATUS = 16'h2103;
   localparam logic [15:0] FSB_IDX_SLAVE = 16'h2110;
   localparam logic [15:0] FSB_IDX_CMD_CTRL = 16'h2290;
   localparam logic [15:0] FSB_IDX_CMD_REC = 16'h2291;
   localparam logic [19:0] FSB_ADDR_CTRL = {2'h0, FSB_IDX_CTRL, 2'h0};
   localparam logic [19:0] FSB_ADDR_COUNT = {2'h0, FSB_IDX_STATUS, 2'h0};
   localparam logic [19:0] FSB_ADDR_SLAVE = {2'h0, FSB_IDX_SLAVE, 2'h0};
   localparam logic [19:0] FSB_ADDR_CMD_CTRL = {2'h0, FSB_IDX_CMD_CTRL, 2'h0};
   localparam logic [19:0] FSB_ADDR_REC_COUNT = {2'h0, FSB_IDX_CMD_REC, 2'h0};
   localparam logic [19:0] FSB_ADDR_DIS_MASK = 20'h09000;
   localparam logic [19:0] FSB_ADDR_ENABLED = 20'h09004;
   localparam logic [19:0] FSB_ADDR_IRQ_STAT = 20'h09008;
   localparam logic [19:0] FSB_ADDR_IRQ_MASK = 20'h0900C;
   localparam logic [19:0] FSB_ADDR_REC_BASE = 20'h09010;
   // interface and protocol bit positions
   localparam int FSB_BIT_USB = 0;
   localparam int FSB_BIT_RS485 = 1;
   localparam int FSB_BIT_RS232 = 2;
   localparam int FSB_BIT_CAN = 3;
   localparam int FSB_ETHERNET_IFACE_BIT = 4;
   localparam int FSB_INDUSTRIAL_ETH_SLAVE_BIT = 5;
   localparam int FSB_BIT_SPI = 6;
   localparam int FSB_SERIAL_REGISTER_PROTOCOL_BIT = 16;
   localparam int FSB_TCP_REGISTER_PROTOCOL_BIT = 17;
   localparam int FSB_INDUSTRIAL_IP_PROTOCOL_BIT = 18;
   localparam logic [31:0] FSB_USED_BITS = 32'h0007007F;
   // reset values
   localparam logic [31:0] FSB_CTRL_RST = 32'h00000020;
   localparam logic [7:0] FSB_STATUS_COUNT = 8'h02;
   localparam logic [31:0] FSB_DIS_MASK_RST = 32'h00000000;
   localparam logic [31:0] FSB_ENABLED_RST = 32'h00000020;
   localparam logic [15:0] FSB_SLAVE_RST = 16'h0000;
   localparam logic [7:0] FSB_CMD_CTRL_RST = 8'h01;
   localparam logic [7:0] FSB_REC_COUNT = 8'h04;
   localparam int FSB_CMD_EN_BIT = 0;
   // slave status word fields
   localparam int FSB_SLV_STATE_LSB = 0;
   localparam int FSB_SLV_ERR_BIT = 4;
   localparam int FSB_SLV_SYNC_BIT = 5;
   // interrupt status bits
   localparam int FSB_IRQ_W = 5;
   localparam int FSB_IRQ_STATE = 0;
   localparam int FSB_IRQ_ERR = 1;
   localparam int FSB_IRQ_SYNC = 2;
   localparam int FSB_IRQ_ACTIVE = 3;
   localparam int FSB_IRQ_CMD = 4;
   // input record: 4 entries, entry 3 is the command byte
   localparam int FSB_REC_DEPTH = 4;
   localparam logic [1:0] FSB_REC_CMD_ENTRY = 2'h3;

   typedef enum logic [3:0] {
      FSB_BUS_INIT = 4'h1,
      FSB_BUS_PREOP = 4'h2,
      FSB_BUS_BOOT = 4'h3,
      FSB_BUS_SAFEOP = 4'h4,
      FSB_BUS_OP = 4'h8
   } fsb_bus_state_t;

   typedef enum logic [1:0] {
      FSB_ST_IDLE = 2'b00,
      FSB_ST_WAIT = 2'b01,
      FSB_ST_LOAD = 2'b10
   } fsb_bus_phase_t;
endpackage

// >>> inc/fsb_rec_if.sv
// carrier between the bank and its input record memory
`timescale 1ns/100ps
interface fsb_rec_if;
   logic we;
   logic [1:0] waddr;
   logic [31:0] wdata;
   logic [1:0] raddr;
   logic [31:0] rdata;
   modport ctl (output we, output waddr, output wdata, output raddr,
      input rdata);
   modport mem (input we, input waddr, input wdata, input raddr,
      output rdata);
endinterface

// >>> verif/fsb_bank_assertions.sv
// checker of bus timing, status reads and enable outputs of the bank
`timescale 1ns/100ps
module fsb_bank_assertions
   import fsb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [31:0] deactivatable_pin,
   input wire logic [31:0] iface_active_pin,
   input wire logic [3:0] slave_bus_state_pin,
   input wire logic slave_err_pin,
   input wire logic slave_sync_pin,
   input wire logic [31:0] iface_enable,
   input wire logic drive_command_interface_en,
   input wire logic cmd_start,
   input wire logic irq
);
   logic [3:0] calm;
   wire take = hsel && htrans[1] && hready && hreadyout;
   // edges since any pin moved; status reads are judged only when calm,
   // since the pins pass a synchroniser first
   always_ff @(posedge sys_clk) begin
      if (!rst_n || $changed({deactivatable_pin, iface_active_pin,
            slave_bus_state_pin, slave_err_pin, slave_sync_pin}))
         calm <= 4'h0;
      else if (calm != 4'hF)
         calm <= calm + 4'h1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_rd(a);
      take && !hwrite && haddr == {12'h000, a};
   endsequence
   sequence s_wait;
      !hreadyout ##1 !hreadyout ##1 hreadyout;
   endsequence
   property p_wait; take |=> s_wait; endproperty
   a_wait: assert property (p_wait) else $error("wait states wrong");
   property p_okay; hresp == 1'b0; endproperty
   a_okay: assert property (p_okay) else $error("response not okay");
   property p_count;
      s_rd(FSB_ADDR_COUNT) |-> ##3 hrdata == 32'h00000002;
   endproperty
   a_count: assert property (p_count) else $error("bad count");
   // read data at the third edge carry the pins of the edge before the
   // take: two sync stages, the status flop and the read flop
   property p_enabled;
      s_rd(FSB_ADDR_ENABLED) ##0 calm > 4'h4 |->
         ##3 hrdata == ($past(iface_active_pin, 4) & FSB_USED_BITS);
   endproperty
   a_enabled: assert property (p_enabled)
      else $error("bad enabled");
   property p_mask;
      s_rd(FSB_ADDR_DIS_MASK) ##0 calm > 4'h4 |->
         ##3 hrdata == ($past(deactivatable_pin, 4) & FSB_USED_BITS);
   endproperty
   a_mask: assert property (p_mask) else $error("bad mask");
   property p_slave;
      s_rd(FSB_ADDR_SLAVE) ##0 calm > 4'h4 |-> ##3 hrdata[31:4] ==
         {26'h0, $past(slave_sync_pin, 4), $past(slave_err_pin, 4)};
   endproperty
   a_slave: assert property (p_slave)
      else $error("bad flags");
   property p_unused; (iface_enable & ~FSB_USED_BITS) == 32'h0; endproperty
   a_unused: assert property (p_unused)
      else $error("unused bit on");
   // a write at edge t sees the pin of t-3; the output shows it two later
   property p_locked;
      (deactivatable_pin == 32'h0) [*5] |=> $stable(iface_enable);
   endproperty
   a_locked: assert property (p_locked)
      else $error("locked moved");
   property p_pulse; cmd_start |=> !cmd_start; endproperty
   a_pulse: assert property (p_pulse) else $error("long pulse");
   property p_gate; cmd_start |-> drive_command_interface_en; endproperty
   a_gate: assert property (p_gate) else $error("start while off");
   property p_rst;
      $rose(rst_n) |-> iface_enable == 32'h00000020 &&
         drive_command_interface_en && !irq && !cmd_start;
   endproperty
   a_rst: assert property (p_rst) else $error("bad reset");
endmodule // fsb_bank_assertions

bind fsb_bank fsb_bank_assertions fsb_bank_assertions_i (.sys_clk, .rst_n,
   .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata,
   .deactivatable_pin, .iface_active_pin, .slave_bus_state_pin,
   .slave_err_pin, .slave_sync_pin, .iface_enable,
   .drive_command_interface_en, .cmd_start, .irq);

// >>> verif/fsb_iface_model.sv
// model of the interface hardware and slave module behind the bank
`timescale 1ns/100ps
module fsb_iface_model
   import fsb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [31:0] iface_enable,
   input wire logic [31:0] want_mask,
   input wire logic [5:0] want_slave,
   output logic [31:0] deactivatable_pin,
   output logic [31:0] iface_active_pin,
   output logic [3:0] slave_bus_state_pin,
   output logic slave_err_pin,
   output logic slave_sync_pin
);
   // pins settle at the first edge, the active set at the second, well inside the bank's reset; an
   // interface comes up one cycle after it is switched on, so the
   // active set lags the requested one
   always @(posedge sys_clk) begin
      iface_active_pin <= iface_enable;
      deactivatable_pin <= want_mask;
      {slave_sync_pin, slave_err_pin, slave_bus_state_pin} <=
         want_slave;
   end
endmodule // fsb_iface_model

// >>> verif/tb_top.sv
// self-checking bench of the fieldbus select and status bank
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("BAD at %0t got %h exp %h", $time, (g), (e)); end end
module tb_top
   import fsb_pkg::*;
;
   logic sys_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq;
   logic [31:0] haddr, hwdata, hrdata, iface_enable, q, want_mask, exp;
   logic [1:0] htrans;
   logic [5:0] want_slave;
   logic drive_command_interface_en, cmd_start, clk_en;
   logic [7:0] cmd_code;
   logic [31:0] dis_pin, act_pin;
   logic [3:0] st_pin;
   logic err_pin, sync_pin;
   int bad_count, cmp_count, pulses, p0;
   int pos[10] = '{FSB_BIT_USB, FSB_BIT_RS485, FSB_BIT_RS232, FSB_BIT_CAN,
      FSB_ETHERNET_IFACE_BIT, FSB_INDUSTRIAL_ETH_SLAVE_BIT, FSB_BIT_SPI,
      FSB_SERIAL_REGISTER_PROTOCOL_BIT, FSB_TCP_REGISTER_PROTOCOL_BIT,
      FSB_INDUSTRIAL_IP_PROTOCOL_BIT};
   logic [3:0] states[5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
   fsb_bank fsb_bank_i (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .deactivatable_pin(dis_pin), .iface_active_pin(act_pin),
      .slave_bus_state_pin(st_pin), .slave_err_pin(err_pin),
      .slave_sync_pin(sync_pin), .iface_enable(iface_enable),
      .drive_command_interface_en(drive_command_interface_en),
      .cmd_start(cmd_start), .cmd_code(cmd_code), .irq(irq));
   fsb_iface_model fsb_iface_model_i (.sys_clk(sys_clk),
      .iface_enable(iface_enable), .want_mask(want_mask),
      .want_slave(want_slave), .deactivatable_pin(dis_pin),
      .iface_active_pin(act_pin), .slave_bus_state_pin(st_pin),
      .slave_err_pin(err_pin), .slave_sync_pin(sync_pin));
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // pulses are counted on the edge after they appear
   always @(posedge sys_clk) if (cmd_start === 1'b1) pulses++;
   task final_report;
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ready and read data are taken at the same rising edge; a hung slave
   // ends the run
   task wait_ready;
      int n;
      n = 0;
      while (n < 40) begin
         @(posedge sys_clk);
         if (hreadyout === 1'b1) break;
         n++;
      end
      q = hrdata;
      if (n == 40) begin
         bad_count++;
         final_report();
      end
   endtask
   task xfer(input logic w, input logic [19:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {12'h000, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
   endtask
   task wr(input logic [19:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   task rd(input logic [19:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK(q, e)
   endtask
   task do_reset;
      rst_n <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      `CHK(iface_enable, 32'h00000020)
   endtask
   task t_reset;
      rd(FSB_ADDR_CTRL, 32'h00000020);
      rd(FSB_ADDR_COUNT, 32'h00000002);
      rd(FSB_ADDR_SLAVE, 32'h00000000);
      rd(FSB_ADDR_CMD_CTRL, 32'h00000001);
      rd(FSB_ADDR_ENABLED, 32'h00000020);
      rd(FSB_ADDR_DIS_MASK, 32'h00000000);
      wr(20'h09100, 32'hFFFFFFFF);
      rd(20'h09100, 32'h00000000);
      wr(FSB_ADDR_COUNT, 32'hFFFFFFFF);
      rd(FSB_ADDR_COUNT, 32'h00000002);
      wr(FSB_ADDR_CTRL, 32'h00000000);
      rd(FSB_ADDR_CTRL, 32'h00000020);
      wr(FSB_ADDR_SLAVE, 32'hFFFFFFFF);
      rd(FSB_ADDR_SLAVE, 32'h00000000);
      $display("test reset done");
   endtask
   task t_bits;
      want_mask <= 32'hFFFFFFFF;
      repeat (6) @(posedge sys_clk);
      rd(FSB_ADDR_DIS_MASK, 32'h0007007F);
      wr(FSB_ADDR_CTRL, 32'hFFFFFFFF);
      rd(FSB_ADDR_CTRL, 32'h0007007F);
      repeat (6) @(posedge sys_clk);
      rd(FSB_ADDR_ENABLED, 32'h0007007F);
      exp = 32'h0007007F;
      // free one bit at a time; clearing all must drop only that bit
      foreach (pos[i]) begin
         want_mask <= 32'h1 << pos[i];
         repeat (6) @(posedge sys_clk);
         wr(FSB_ADDR_CTRL, 32'h00000000);
         exp = exp & ~(32'h1 << pos[i]);
         rd(FSB_ADDR_CTRL, exp);
         `CHK(iface_enable, exp)
      end
      $display("test bits done");
   endtask
   task t_slave;
      foreach (states[i]) begin
         want_slave <= {i[1:0], states[i]};
         repeat (6) @(posedge sys_clk);
         rd(FSB_ADDR_SLAVE, {26'h0, i[1:0], states[i]});
      end
      want_slave <= 6'h05;
      repeat (6) @(posedge sys_clk);
      rd(FSB_ADDR_SLAVE, 32'h00000008);
      $display("test slave done");
   endtask
   task t_irq;
      wr(FSB_ADDR_IRQ_MASK, 32'h0000001F);
      wr(FSB_ADDR_IRQ_STAT, 32'h0000001F);
      `CHK(irq, 1'b0)
      want_slave <= 6'h18;
      repeat (6) @(posedge sys_clk);
      `CHK(irq, 1'b1)
      rd(FSB_ADDR_IRQ_STAT, 32'h00000002);
      wr(FSB_ADDR_IRQ_MASK, 32'h00000000);
      `CHK(irq, 1'b0)
      wr(FSB_ADDR_IRQ_STAT, 32'h00000002);
      wr(FSB_ADDR_IRQ_MASK, 32'h0000001F);
      `CHK(irq, 1'b0)
      // a low clock enable holds the sync event back until it returns
      clk_en <= 1'b0;
      want_slave <= 6'h38;
      repeat (8) @(posedge sys_clk);
      `CHK(irq, 1'b0)
      clk_en <= 1'b1;
      repeat (8) @(posedge sys_clk);
      `CHK(irq, 1'b1)
      rd(FSB_ADDR_IRQ_STAT, 32'h00000004);
      wr(FSB_ADDR_IRQ_STAT, 32'h0000001F);
      $display("test irq done");
   endtask
   task t_cmd;
      rd(FSB_ADDR_REC_COUNT, 32'h00000004);
      wr(FSB_ADDR_REC_BASE, 32'h12345678);
      rd(FSB_ADDR_REC_BASE, 32'h12345678);
      p0 = pulses;
      wr(20'h0901C, 32'h000000A5);
      repeat (2) @(posedge sys_clk);
      `CHK(pulses, p0 + 1)
      `CHK(cmd_code, 8'hA5)
      rd(FSB_ADDR_IRQ_STAT, 32'h00000010);
      wr(FSB_ADDR_CMD_CTRL, 32'h00000000);
      `CHK(drive_command_interface_en, 1'b0)
      wr(20'h0901C, 32'h0000005A);
      repeat (2) @(posedge sys_clk);
      `CHK(pulses, p0 + 1)
      `CHK(cmd_code, 8'hA5)
      rd(FSB_ADDR_CMD_CTRL, 32'h00000000);
      wr(FSB_ADDR_CMD_CTRL, 32'h00000001);
      `CHK(drive_command_interface_en, 1'b1)
      $display("test cmd done");
   endtask
   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hwdata = 32'h0;
      want_mask = 32'h0;
      want_slave = 6'h00;
      bad_count = 0;
      cmp_count = 0;
      pulses = 0;
      @(posedge sys_clk);
      do_reset();
      t_reset();
      t_bits();
      t_slave();
      t_irq();
      t_cmd();
      do_reset();
      rd(FSB_ADDR_CTRL, 32'h00000020);
      $display("test second reset done");
      final_report();
   end
endmodule // tb_top
